// [e1sa_pkg.sv]
// shared constants and carriers for the e1 spare/international bit access block
package e1sa_pkg;

  // register offsets on the 9-bit framer register port
  localparam logic [8:0] E1SA_ADDR_RX_ALIGN = 9'h064;
  localparam logic [8:0] E1SA_ADDR_RX_NONALIGN = 9'h065;
  localparam logic [8:0] E1SA_ADDR_RX_MF_BASE = 9'h066;
  localparam logic [8:0] E1SA_ADDR_SPARE_NOW = 9'h06E;
  localparam logic [8:0] E1SA_ADDR_SA6_CODE = 9'h06F;
  localparam logic [8:0] E1SA_ADDR_RLS_TWO = 9'h091;
  localparam logic [8:0] E1SA_ADDR_RLS_SEVEN = 9'h096;
  localparam logic [8:0] E1SA_ADDR_RIM_SEVEN = 9'h0A6;
  localparam logic [8:0] E1SA_ADDR_MON_SEL = 9'h0E8;
  localparam logic [8:0] E1SA_ADDR_TX_SRC = 9'h114;
  localparam logic [8:0] E1SA_ADDR_TX_MF_BASE = 9'h166;
  localparam logic [8:0] E1SA_ADDR_TLS_ONE = 9'h190;

  // multiframe register bank: si align, si nonalign, remote alarm, sa4..sa8
  localparam int E1SA_MF_REGS = 8;
  localparam int E1SA_MF_SI_ALIGN = 0;
  localparam int E1SA_MF_SI_NONALIGN = 1;
  localparam int E1SA_MF_ALARM = 2;
  localparam int E1SA_MF_SA4 = 3;

  // status bit positions
  localparam int E1SA_RECEIVE_LATCHED_STATUS_TWO_ALIGN_BIT = 0;
  localparam int E1SA_RECEIVE_LATCHED_STATUS_TWO_MF_BIT = 1;
  localparam int E1SA_RECEIVE_LATCHED_STATUS_SEVEN_SA_CHG_BIT = 0;
  localparam int E1SA_RECEIVE_LATCHED_STATUS_SEVEN_SA6_CHG_BIT = 3;
  localparam int E1SA_TRANSMIT_LATCHED_STATUS_ONE_MF_BIT = 3;

  // ts0 bit layout, bit 7 goes first on the line
  localparam int E1SA_TS0_SI_BIT = 7;
  localparam int E1SA_TS0_ALARM_BIT = 5;
  localparam int E1SA_TS0_SA6_BIT = 2;
  localparam int E1SA_SA_FIELD_W = 5;

  // frame numbers within the crc-4 multiframe
  localparam logic [3:0] E1SA_LAST_FRAME = 4'hF;
  localparam logic [3:0] E1SA_SMF_LAST_FRAME = 4'h7;
  localparam logic [1:0] E1SA_SA6_STABLE_SMF = 2'h3;

  // register reset values
  localparam logic [7:0] E1SA_RESET_BYTE = 8'h00;
  localparam logic [3:0] E1SA_SA6_RESET = 4'h0;

  // host service windows, in microseconds (host side obligations)
  localparam int E1SA_DF_READ_US = 250;
  localparam int E1SA_MF_SERVICE_US = 2000;

  // one received timeslot-0 byte with its frame number
  typedef struct packed {
    logic valid;
    logic [3:0] frame;
    logic [7:0] data;
  } e1sa_ts0_s;

  // transmit request for one frame's timeslot-0 overhead
  typedef struct packed {
    logic valid;
    logic [3:0] frame;
  } e1sa_tx_req_s;

  // overhead bits to insert plus per-bit insert enables
  typedef struct packed {
    logic valid;
    logic [7:0] data;
    logic [7:0] enable;
  } e1sa_tx_ins_s;

endpackage

// [e1sa_latch_reg.sv]
// latched status byte with write-one-to-clear and set-over-clear priority
`timescale 1ns/1ps
`default_nettype none
module e1sa_latch_reg #(
  parameter int WIDTH = 8
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // hardware events and host clear
  input wire logic [WIDTH-1:0] set_in,
  input wire logic clr_wr,
  input wire logic [WIDTH-1:0] clr_data,
  // latched value
  output logic [WIDTH-1:0] flags
);
  logic [WIDTH-1:0] flags_reg;
  logic [WIDTH-1:0] flags_next;

  // an event in the clearing cycle survives the clear
  always_comb
  begin
    flags_next = flags_reg;
    if (clr_wr)
    begin
      flags_next = flags_next & ~clr_data;
    end
    flags_next = flags_next | set_in;
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      flags_reg <= '0;
    end
    else
    begin
      flags_reg <= flags_next;
    end
  end

  assign flags = flags_reg;
endmodule
`default_nettype wire

// [e1sa_spare_access.sv]
// e1 spare and international overhead bit access with host register port
`timescale 1ns/1ps
`default_nettype none
module e1sa_spare_access (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // host register port
  input wire logic [8:0] host_addr,
  input wire logic host_wr,
  input wire logic host_rd,
  input wire logic [7:0] host_wdata,
  output logic [7:0] host_rdata,
  // receive framer side
  input wire e1sa_pkg::e1sa_ts0_s rx_ts0,
  // transmit framer side
  input wire e1sa_pkg::e1sa_tx_req_s tx_req,
  output e1sa_pkg::e1sa_tx_ins_s tx_ins,
  // interrupt
  output logic interrupt_out_n
);
  import e1sa_pkg::*;

  logic rx_align;
  logic rx_nonalign;
  logic rx_mf_end;
  logic rx_smf_end;
  assign rx_align = rx_ts0.valid && !rx_ts0.frame[0];
  assign rx_nonalign = rx_ts0.valid && rx_ts0.frame[0];
  assign rx_mf_end = rx_ts0.valid && (rx_ts0.frame == E1SA_LAST_FRAME);
  assign rx_smf_end = rx_ts0.valid && (rx_ts0.frame[2:0] == E1SA_SMF_LAST_FRAME[2:0]);

  // host writable control: transmit bank, source control, monitor select, mask
  logic [7:0] tx_mf_reg [E1SA_MF_REGS];
  logic [7:0] tx_mf_next [E1SA_MF_REGS];
  logic [7:0] tx_src_reg, tx_src_next;
  logic [7:0] mon_sel_reg, mon_sel_next;
  logic [7:0] receive_interrupt_mask_seven_reg, receive_interrupt_mask_seven_next;

  always_comb
  begin
    tx_mf_next = tx_mf_reg;
    tx_src_next = tx_src_reg;
    mon_sel_next = mon_sel_reg;
    receive_interrupt_mask_seven_next = receive_interrupt_mask_seven_reg;
    if (host_wr)
    begin
      for (int i = 0; i < E1SA_MF_REGS; i++)
      begin
        if (host_addr == E1SA_ADDR_TX_MF_BASE + 9'(i))
        begin
          tx_mf_next[i] = host_wdata;
        end
      end
      if (host_addr == E1SA_ADDR_TX_SRC)
      begin
        tx_src_next = host_wdata;
      end
      if (host_addr == E1SA_ADDR_MON_SEL)
      begin
        mon_sel_next = host_wdata;
      end
      if (host_addr == E1SA_ADDR_RIM_SEVEN)
      begin
        receive_interrupt_mask_seven_next = host_wdata;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < E1SA_MF_REGS; i++)
      begin
        tx_mf_reg[i] <= E1SA_RESET_BYTE;
      end
      tx_src_reg <= E1SA_RESET_BYTE;
      mon_sel_reg <= E1SA_RESET_BYTE;
      receive_interrupt_mask_seven_reg <= E1SA_RESET_BYTE;
    end
    else
    begin
      tx_mf_reg <= tx_mf_next;
      tx_src_reg <= tx_src_next;
      mon_sel_reg <= mon_sel_next;
      receive_interrupt_mask_seven_reg <= receive_interrupt_mask_seven_next;
    end
  end

  // receive capture: double frame, multiframe bank and its shadow
  logic [7:0] rx_align_frame_reg, rx_align_frame_next;
  logic [7:0] rx_nonalign_frame_reg, rx_nonalign_frame_next;
  logic [7:0] rx_nonalign_frame_capture, rx_nonalign_capture_next;
  logic [7:0] rx_mf_reg [E1SA_MF_REGS];
  logic [7:0] rx_mf_next [E1SA_MF_REGS];
  logic [7:0] rx_shadow_reg [E1SA_MF_REGS];
  logic [7:0] rx_shadow_next [E1SA_MF_REGS];
  logic [2:0] rx_slot;
  assign rx_slot = 3'(7 - int'(rx_ts0.frame[3:1]));

  always_comb
  begin
    rx_align_frame_next = rx_align_frame_reg;
    rx_nonalign_frame_next = rx_nonalign_frame_reg;
    rx_nonalign_capture_next = rx_nonalign_frame_capture;
    rx_shadow_next = rx_shadow_reg;
    rx_mf_next = rx_mf_reg;
    if (rx_align)
    begin
      rx_align_frame_next = rx_ts0.data;
      rx_nonalign_frame_next = rx_nonalign_frame_capture;
      rx_shadow_next[E1SA_MF_SI_ALIGN][rx_slot] = rx_ts0.data[E1SA_TS0_SI_BIT];
    end
    if (rx_nonalign)
    begin
      rx_nonalign_capture_next = rx_ts0.data;
      rx_shadow_next[E1SA_MF_SI_NONALIGN][rx_slot] = rx_ts0.data[E1SA_TS0_SI_BIT];
      rx_shadow_next[E1SA_MF_ALARM][rx_slot] = rx_ts0.data[E1SA_TS0_ALARM_BIT];
      for (int s = 0; s < E1SA_SA_FIELD_W; s++)
      begin
        rx_shadow_next[E1SA_MF_SA4 + s][rx_slot] = rx_ts0.data[E1SA_SA_FIELD_W - 1 - s];
      end
    end
    if (rx_mf_end)
    begin
      rx_mf_next = rx_shadow_next;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rx_align_frame_reg <= E1SA_RESET_BYTE;
      rx_nonalign_frame_reg <= E1SA_RESET_BYTE;
      rx_nonalign_frame_capture <= E1SA_RESET_BYTE;
      for (int i = 0; i < E1SA_MF_REGS; i++)
      begin
        rx_mf_reg[i] <= E1SA_RESET_BYTE;
        rx_shadow_reg[i] <= E1SA_RESET_BYTE;
      end
    end
    else
    begin
      rx_align_frame_reg <= rx_align_frame_next;
      rx_nonalign_frame_reg <= rx_nonalign_frame_next;
      rx_nonalign_frame_capture <= rx_nonalign_capture_next;
      rx_mf_reg <= rx_mf_next;
      rx_shadow_reg <= rx_shadow_next;
    end
  end

  // sa monitoring and sa6 codeword tracking
  logic [4:0] spare_bits_reg, spare_bits_next;
  logic [3:0] spare_six_codeword, sa6_code_next;
  logic [3:0] sa6_acc_reg, sa6_acc_next;
  logic [3:0] sa6_cand_reg, sa6_cand_next;
  logic [1:0] sa6_run_reg, sa6_run_next;
  logic [3:0] sa6_word;
  logic spare_change_set;
  logic spare_six_change_set;

  always_comb
  begin
    spare_bits_next = spare_bits_reg;
    sa6_acc_next = sa6_acc_reg;
    sa6_cand_next = sa6_cand_reg;
    sa6_run_next = sa6_run_reg;
    sa6_code_next = spare_six_codeword;
    spare_change_set = 1'b0;
    spare_six_change_set = 1'b0;
    sa6_word = {sa6_acc_reg[2:0], rx_ts0.data[E1SA_TS0_SA6_BIT]};
    if (rx_nonalign)
    begin
      spare_bits_next = rx_ts0.data[4:0];
      spare_change_set = |((rx_ts0.data[4:0] ^ spare_bits_reg) & mon_sel_reg[4:0]);
      sa6_acc_next = sa6_word;
    end
    if (rx_smf_end)
    begin
      // a new candidate restarts the run, so one glitch costs three more
      if (sa6_word == sa6_cand_reg)
      begin
        sa6_run_next = (sa6_run_reg == E1SA_SA6_STABLE_SMF) ? sa6_run_reg : sa6_run_reg + 2'h1;
      end
      else
      begin
        sa6_run_next = 2'h1;
      end
      sa6_cand_next = sa6_word;
      if (sa6_run_next == E1SA_SA6_STABLE_SMF && sa6_word != spare_six_codeword)
      begin
        sa6_code_next = sa6_word;
        spare_six_change_set = 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      spare_bits_reg <= '0;
      spare_six_codeword <= E1SA_SA6_RESET;
      sa6_acc_reg <= E1SA_SA6_RESET;
      sa6_cand_reg <= E1SA_SA6_RESET;
      sa6_run_reg <= 2'h0;
    end
    else
    begin
      spare_bits_reg <= spare_bits_next;
      spare_six_codeword <= sa6_code_next;
      sa6_acc_reg <= sa6_acc_next;
      sa6_cand_reg <= sa6_cand_next;
      sa6_run_reg <= sa6_run_next;
    end
  end

  // transmit insertion: bank sampled at multiframe start, kept until the next one
  logic [7:0] tx_samp_reg [E1SA_MF_REGS];
  logic [7:0] tx_samp_next [E1SA_MF_REGS];
  logic [7:0] tx_src_samp [E1SA_MF_REGS];
  e1sa_tx_ins_s tx_ins_reg, tx_ins_next;
  logic tx_mf_start;
  logic [2:0] tx_slot;
  assign tx_mf_start = tx_req.valid && (tx_req.frame == 4'h0);
  assign tx_slot = 3'(7 - int'(tx_req.frame[3:1]));

  always_comb
  begin
    tx_samp_next = tx_samp_reg;
    tx_src_samp = tx_mf_start ? tx_mf_reg : tx_samp_reg;
    tx_ins_next = '0;
    if (tx_mf_start)
    begin
      tx_samp_next = tx_mf_reg;
    end
    if (tx_req.valid)
    begin
      tx_ins_next.valid = 1'b1;
      if (!tx_req.frame[0])
      begin
        tx_ins_next.data[E1SA_TS0_SI_BIT] = tx_src_samp[E1SA_MF_SI_ALIGN][tx_slot];
        tx_ins_next.enable[E1SA_TS0_SI_BIT] = tx_src_reg[7];
      end
      else
      begin
        tx_ins_next.data[E1SA_TS0_SI_BIT] = tx_src_samp[E1SA_MF_SI_NONALIGN][tx_slot];
        tx_ins_next.data[E1SA_TS0_ALARM_BIT] = tx_src_samp[E1SA_MF_ALARM][tx_slot];
        for (int s = 0; s < E1SA_SA_FIELD_W; s++)
        begin
          tx_ins_next.data[E1SA_SA_FIELD_W - 1 - s] = tx_src_samp[E1SA_MF_SA4 + s][tx_slot];
        end
        // old bank is reused when the host misses its reload window
        tx_ins_next.enable = {tx_src_reg[6], 1'b0, tx_src_reg[5:0]};
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < E1SA_MF_REGS; i++)
      begin
        tx_samp_reg[i] <= E1SA_RESET_BYTE;
      end
      tx_ins_reg <= '0;
    end
    else
    begin
      tx_samp_reg <= tx_samp_next;
      tx_ins_reg <= tx_ins_next;
    end
  end
  assign tx_ins = tx_ins_reg;

  // latched status registers
  logic [7:0] receive_latched_status_two, receive_latched_status_seven, transmit_latched_status_one;
  logic [7:0] receive_latched_status_two_set, receive_latched_status_seven_set, transmit_latched_status_one_set;
  always_comb
  begin
    receive_latched_status_two_set = '0;
    receive_latched_status_seven_set = '0;
    transmit_latched_status_one_set = '0;
    receive_latched_status_two_set[E1SA_RECEIVE_LATCHED_STATUS_TWO_ALIGN_BIT] = rx_align;
    receive_latched_status_two_set[E1SA_RECEIVE_LATCHED_STATUS_TWO_MF_BIT] = rx_mf_end;
    receive_latched_status_seven_set[E1SA_RECEIVE_LATCHED_STATUS_SEVEN_SA_CHG_BIT] = spare_change_set;
    receive_latched_status_seven_set[E1SA_RECEIVE_LATCHED_STATUS_SEVEN_SA6_CHG_BIT] = spare_six_change_set;
    transmit_latched_status_one_set[E1SA_TRANSMIT_LATCHED_STATUS_ONE_MF_BIT] = tx_mf_start;
  end

  e1sa_latch_reg #(.WIDTH(8)) u_receive_latched_status_two (.core_clk(core_clk), .rst_n(rst_n), .set_in(receive_latched_status_two_set),
    .clr_wr(host_wr && host_addr == E1SA_ADDR_RLS_TWO), .clr_data(host_wdata), .flags(receive_latched_status_two));
  e1sa_latch_reg #(.WIDTH(8)) u_receive_latched_status_seven (.core_clk(core_clk), .rst_n(rst_n), .set_in(receive_latched_status_seven_set),
    .clr_wr(host_wr && host_addr == E1SA_ADDR_RLS_SEVEN), .clr_data(host_wdata), .flags(receive_latched_status_seven));
  e1sa_latch_reg #(.WIDTH(8)) u_transmit_latched_status_one (.core_clk(core_clk), .rst_n(rst_n), .set_in(transmit_latched_status_one_set),
    .clr_wr(host_wr && host_addr == E1SA_ADDR_TLS_ONE), .clr_data(host_wdata), .flags(transmit_latched_status_one));

  // only mask seven exists here; the other status bytes are polled
  assign interrupt_out_n = ~|(receive_latched_status_seven & receive_interrupt_mask_seven_reg);

  // read data, registered one cycle after the read strobe
  logic [7:0] rdata_reg, rdata_next;
  always_comb
  begin
    rdata_next = rdata_reg;
    if (host_rd)
    begin
      rdata_next = E1SA_RESET_BYTE;
      for (int i = 0; i < E1SA_MF_REGS; i++)
      begin
        if (host_addr == E1SA_ADDR_RX_MF_BASE + 9'(i))
        begin
          rdata_next = rx_mf_reg[i];
        end
        if (host_addr == E1SA_ADDR_TX_MF_BASE + 9'(i))
        begin
          rdata_next = tx_mf_reg[i];
        end
      end
      unique case (host_addr)
        E1SA_ADDR_RX_ALIGN: rdata_next = rx_align_frame_reg;
        E1SA_ADDR_RX_NONALIGN: rdata_next = rx_nonalign_frame_reg;
        E1SA_ADDR_SPARE_NOW: rdata_next = {3'h0, spare_bits_reg};
        E1SA_ADDR_SA6_CODE: rdata_next = {4'h0, spare_six_codeword};
        E1SA_ADDR_RLS_TWO: rdata_next = receive_latched_status_two;
        E1SA_ADDR_RLS_SEVEN: rdata_next = receive_latched_status_seven;
        E1SA_ADDR_RIM_SEVEN: rdata_next = receive_interrupt_mask_seven_reg;
        E1SA_ADDR_MON_SEL: rdata_next = mon_sel_reg;
        E1SA_ADDR_TX_SRC: rdata_next = tx_src_reg;
        E1SA_ADDR_TLS_ONE: rdata_next = transmit_latched_status_one;
        default: ;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rdata_reg <= E1SA_RESET_BYTE;
    end
    else
    begin
      rdata_reg <= rdata_next;
    end
  end
  assign host_rdata = rdata_reg;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  chk_align_flag_set: assert property (rx_align |=> receive_latched_status_two[E1SA_RECEIVE_LATCHED_STATUS_TWO_ALIGN_BIT])
    else $error("align refresh did not set its flag");
  chk_align_capture: assert property (rx_align |=> rx_align_frame_reg == $past(rx_ts0.data))
    else $error("align capture missed the frame byte");
  chk_mf_commit: assert property (rx_mf_end |=> receive_latched_status_two[E1SA_RECEIVE_LATCHED_STATUS_TWO_MF_BIT]
    && rx_mf_reg[E1SA_MF_SI_ALIGN] == rx_shadow_reg[E1SA_MF_SI_ALIGN])
    else $error("multiframe bank not refreshed with flag");
  chk_mf_hold: assert property (!rx_mf_end |=> $stable(rx_mf_reg[E1SA_MF_ALARM]))
    else $error("multiframe bank changed mid multiframe");
  chk_tx_sample: assert property (tx_mf_start |=> transmit_latched_status_one[E1SA_TRANSMIT_LATCHED_STATUS_ONE_MF_BIT]
    && tx_samp_reg[E1SA_MF_SA4] == $past(tx_mf_reg[E1SA_MF_SA4]))
    else $error("transmit bank not sampled at flag");
  chk_tx_disabled: assert property (tx_ins.valid && tx_src_reg == 8'h00
    && $stable(tx_src_reg) |-> tx_ins.enable == 8'h00)
    else $error("insert enabled without source control");
  chk_sa_unwatched: assert property (mon_sel_reg == 8'h00 |-> !spare_change_set)
    else $error("unwatched sa bit raised a change");
  chk_flag_sticky: assert property (receive_latched_status_seven[E1SA_RECEIVE_LATCHED_STATUS_SEVEN_SA_CHG_BIT] && !host_wr
    |=> receive_latched_status_seven[E1SA_RECEIVE_LATCHED_STATUS_SEVEN_SA_CHG_BIT])
    else $error("latched flag dropped without host clear");
  chk_irq_level: assert property (receive_latched_status_seven[0] && receive_interrupt_mask_seven_reg[0] |-> !interrupt_out_n)
    else $error("unmasked flag not driving interrupt");
  chk_irq_masked: assert property (receive_interrupt_mask_seven_reg == 8'h00 |-> interrupt_out_n)
    else $error("masked flags drove interrupt");
  chk_sa6_update: assert property (spare_six_change_set
    |=> spare_six_codeword != $past(spare_six_codeword) && receive_latched_status_seven[E1SA_RECEIVE_LATCHED_STATUS_SEVEN_SA6_CHG_BIT])
    else $error("sa6 update did not change code and flag");

  cov_mf_end: cover property (rx_mf_end ##1 host_rd && host_addr == E1SA_ADDR_RX_MF_BASE);
  cov_sa_change: cover property (spare_change_set ##1 !interrupt_out_n);
  cov_sa6_change: cover property (spare_six_change_set);
  cov_set_clear_same: cover property (rx_align && host_wr && host_addr == E1SA_ADDR_RLS_TWO);
endmodule
`default_nettype wire

// [e1sa_far_end.sv]
// line-side framer model: sends timeslot-0 bytes and transmit requests for one multiframe
`timescale 1ns/1ps
`default_nettype none
module e1sa_far_end
  import e1sa_pkg::*;
(
  // clock
  input wire logic core_clk,
  // control from bench
  input wire logic start,
  input wire logic rx_en,
  input wire logic tx_en,
  input wire logic [7:0] seed,
  output logic busy,
  // framer side
  output e1sa_ts0_s rx_ts0,
  output e1sa_tx_req_s tx_req
);
  initial
  begin
    rx_ts0 = '0;
    tx_req = '0;
    busy = 1'b0;
  end
  // frames strictly 0..15 with idle gaps; idle data is inverted so stale bytes never match
  always
  begin
    @(posedge core_clk);
    if (start)
    begin
      busy <= 1'b1;
      for (int f = 0; f < 16; f++)
      begin
        rx_ts0 <= '{rx_en, f[3:0], seed ^ {f[3:0], f[3:0]}};
        tx_req <= '{tx_en, f[3:0]};
        @(posedge core_clk);
        rx_ts0.valid <= 1'b0;
        rx_ts0.data <= ~rx_ts0.data;
        tx_req.valid <= 1'b0;
        repeat (3) @(posedge core_clk);
      end
      busy <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// [e1sa_spare_access_tb.sv]
// self-checking bench for the spare bit access block
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin checks_done++; if ((e) !== (g)) begin mismatches++; \
  $display("unexpected %s expected %h seen %h", nm, e, g); end end
module e1sa_spare_access_tb;
  import e1sa_pkg::*;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [8:0] host_addr = '0;
  logic host_wr = 1'b0;
  logic host_rd = 1'b0;
  logic [7:0] host_wdata = '0;
  logic [7:0] host_rdata;
  e1sa_ts0_s rx_ts0;
  e1sa_tx_req_s tx_req;
  e1sa_tx_ins_s tx_ins;
  logic interrupt_out_n;
  logic start = 1'b0;
  logic rx_en = 1'b0;
  logic tx_en = 1'b0;
  logic [7:0] seed = 8'h5A;
  logic busy;
  logic [7:0] tbank [8];
  logic [7:0] ins_d [16];
  logic [7:0] ins_e [16];
  logic [3:0] req_f;
  int mismatches = 0;
  int checks_done = 0;

  initial
  begin
    forever #10 core_clk = ~core_clk;
  end

  e1sa_spare_access u_e1sa_spare_access (.core_clk(core_clk), .rst_n(rst_n),
    .host_addr(host_addr), .host_wr(host_wr), .host_rd(host_rd), .host_wdata(host_wdata),
    .host_rdata(host_rdata), .rx_ts0(rx_ts0), .tx_req(tx_req), .tx_ins(tx_ins),
    .interrupt_out_n(interrupt_out_n));
  e1sa_far_end u_e1sa_far_end (.core_clk(core_clk), .start(start), .rx_en(rx_en),
    .tx_en(tx_en), .seed(seed), .busy(busy), .rx_ts0(rx_ts0), .tx_req(tx_req));

  // capture each inserted overhead byte under the frame that asked for it
  always @(posedge core_clk)
  begin
    if (tx_req.valid)
      req_f <= tx_req.frame;
    if (tx_ins.valid)
    begin
      ins_d[req_f] <= tx_ins.data;
      ins_e[req_f] <= tx_ins.enable;
    end
  end

  task automatic wr(input logic [8:0] a, input logic [7:0] d);
    @(posedge core_clk);
    host_wr <= 1'b1;
    host_addr <= a;
    host_wdata <= d;
    @(posedge core_clk);
    host_wr <= 1'b0;
  endtask

  task automatic rd(input logic [8:0] a, input logic [7:0] e);
    @(posedge core_clk);
    host_rd <= 1'b1;
    host_addr <= a;
    @(posedge core_clk);
    host_rd <= 1'b0;
    #1;
    `CHK("host_rdata", e, host_rdata)
  endtask

  task automatic run_mf(input logic r, input logic t);
    @(posedge core_clk);
    rx_en <= r;
    tx_en <= t;
    start <= 1'b1;
    @(posedge core_clk);
    start <= 1'b0;
    @(posedge core_clk);
    for (int i = 0; i < 200 && busy; i++)
      @(posedge core_clk);
    repeat (2) @(posedge core_clk);
  endtask

  function automatic logic [7:0] fdat(input int f);
    return seed ^ {f[3:0], f[3:0]};
  endfunction

  // multiframe receive bank: bit 7 holds frames 0/1, bit 0 frames 14/15
  function automatic logic [7:0] bank_exp(input int idx);
    logic [7:0] r;
    logic [7:0] nal;
    logic [7:0] al;
    r = '0;
    for (int k = 0; k < 8; k++)
    begin
      nal = fdat(2 * k + 1);
      al = fdat(2 * k);
      case (idx)
        0: r[7 - k] = al[7];
        1: r[7 - k] = nal[7];
        2: r[7 - k] = nal[5];
        default: r[7 - k] = nal[7 - idx];
      endcase
    end
    return r;
  endfunction

  task automatic test_reset_values;
    rd(E1SA_ADDR_RLS_TWO, 8'h00);
    rd(E1SA_ADDR_RLS_SEVEN, 8'h00);
    rd(E1SA_ADDR_RIM_SEVEN, 8'h00);
    rd(E1SA_ADDR_TLS_ONE, 8'h00);
    rd(9'h1FF, 8'h00);
    `CHK("interrupt_out_n", 1'b1, interrupt_out_n)
  endtask

  task automatic test_rx_capture;
    wr(E1SA_ADDR_MON_SEL, 8'h00);
    run_mf(1'b1, 1'b0);
    // reads follow the flag promptly, well inside the host service windows
    rd(E1SA_ADDR_RLS_TWO, 8'h03);
    rd(E1SA_ADDR_RX_ALIGN, fdat(14));
    rd(E1SA_ADDR_RX_NONALIGN, fdat(13));
    for (int i = 0; i < 8; i++)
      rd(E1SA_ADDR_RX_MF_BASE + 9'(i), bank_exp(i));
    rd(E1SA_ADDR_RLS_SEVEN, 8'h00);
    rd(E1SA_ADDR_SA6_CODE, 8'h00);
    wr(E1SA_ADDR_RLS_TWO, 8'h01);
    rd(E1SA_ADDR_RLS_TWO, 8'h02);
    wr(E1SA_ADDR_RLS_TWO, 8'h02);
    rd(E1SA_ADDR_RLS_TWO, 8'h00);
  endtask

  task automatic test_spare_change;
    logic [7:0] last_na;
    // sa8 stays constant, sa7 toggles between nonalign frames
    last_na = fdat(15);
    wr(E1SA_ADDR_MON_SEL, 8'h01);
    run_mf(1'b1, 1'b0);
    rd(E1SA_ADDR_SA6_CODE, 8'h03);
    rd(E1SA_ADDR_RLS_SEVEN, 8'h08);
    rd(E1SA_ADDR_SPARE_NOW, {3'b000, last_na[4:0]});
    wr(E1SA_ADDR_RLS_SEVEN, 8'hFF);
    wr(E1SA_ADDR_MON_SEL, 8'h02);
    run_mf(1'b1, 1'b0);
    rd(E1SA_ADDR_RLS_SEVEN, 8'h01);
    `CHK("interrupt_out_n", 1'b1, interrupt_out_n)
    wr(E1SA_ADDR_RIM_SEVEN, 8'h01);
    @(posedge core_clk);
    #1;
    `CHK("interrupt_out_n", 1'b0, interrupt_out_n)
    rd(E1SA_ADDR_RIM_SEVEN, 8'h01);
    wr(E1SA_ADDR_RLS_SEVEN, 8'h01);
    @(posedge core_clk);
    #1;
    `CHK("interrupt_out_n", 1'b1, interrupt_out_n)
  endtask

  task automatic check_tx(input logic [7:0] src);
    int b;
    logic [7:0] ed;
    logic [7:0] ee;
    for (int f = 0; f < 16; f++)
    begin
      b = 7 - f / 2;
      if (f % 2 == 0)
      begin
        ed = {tbank[0][b], 7'h00};
        ee = {src[7], 7'h00};
      end
      else
      begin
        ed = {tbank[1][b], 1'b0, tbank[2][b], tbank[3][b], tbank[4][b], tbank[5][b],
          tbank[6][b], tbank[7][b]};
        ee = {src[6], 1'b0, src[5:0]};
      end
      `CHK("tx_ins.enable", ee, ins_e[f])
      `CHK("tx_ins.data", ed & ee, ins_d[f] & ee)
    end
  endtask

  task automatic test_tx;
    for (int i = 0; i < 8; i++)
    begin
      tbank[i] = 8'hA5 ^ 8'(i * 8'h13);
      wr(E1SA_ADDR_TX_MF_BASE + 9'(i), tbank[i]);
    end
    wr(E1SA_ADDR_TX_SRC, 8'h7D);
    run_mf(1'b0, 1'b1);
    check_tx(8'h7D);
    rd(E1SA_ADDR_TLS_ONE, 8'h08);
    wr(E1SA_ADDR_TLS_ONE, 8'h08);
    rd(E1SA_ADDR_TLS_ONE, 8'h00);
    // no reload: the earlier bank must go out again
    wr(E1SA_ADDR_TX_SRC, 8'hFF);
    run_mf(1'b0, 1'b1);
    check_tx(8'hFF);
  endtask

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // the whole run needs well under 2000 cycles
  initial
  begin
    repeat (20000) @(posedge core_clk);
    mismatches++;
    end_of_test();
  end

  initial
  begin
    repeat (6) @(posedge core_clk);
    rst_n <= 1'b1;
    test_reset_values();
    test_rx_capture();
    test_spare_change();
    test_tx();
    end_of_test();
  end
endmodule
`default_nettype wire
